// [tb/stm_regs_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "stm_cfg.svh"
module stm_regs_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [`STM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_abort,
  // system level
  input wire logic special_mode,
  input wire logic rsvd_abort_en,
  input wire logic full_performance_mode,
  // outputs
  input wire logic temp_sense_enable,
  input wire logic volt_access_enable,
  input wire logic volt_source_select,
  input wire logic [1:0] temp_test_bits,
  input wire logic temp_irq,
  input wire logic undervolt_irq
);
  logic [2:0] low_q;
  logic ctl_wr;
  assign ctl_wr = reg_wr && reg_addr == `STM_OFF_TEMP_CTRL;
  // cycles since full mode dropped
  always_ff @(posedge mclk) begin
    if (!rst_n || full_performance_mode) begin
      low_q <= 3'h0;
    end else if (low_q != 3'h7) begin
      low_q <= low_q + 3'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_CTRL_WR: assert property (
    ctl_wr |=> {volt_source_select, volt_access_enable, temp_sense_enable}
    == $past(reg_wdata[5:3])) else $error("control bits not taken");
  AST_TEST_LOCK: assert property (
    ctl_wr && !special_mode |=> $stable(temp_test_bits)) else $error("test bits written");
  AST_TEST_SET: assert property (
    ctl_wr && special_mode |=> temp_test_bits == $past(reg_wdata[7:6]))
    else $error("test bits not written");
  AST_TEMP_RO: assert property (
    $past(reg_rd && reg_addr == `STM_OFF_TEMP_CTRL && low_q >= 3'h5) |-> !reg_rdata[2])
    else $error("temp status high outside full mode");
  AST_UV_RO: assert property (
    $past(reg_rd && reg_addr == `STM_OFF_UV_CTRL && low_q >= 3'h5) |-> !reg_rdata[2])
    else $error("undervolt status high outside full mode");
  AST_TIRQ_FALL: assert property (
    $fell(temp_irq) |-> $past(reg_wr)) else $error("temp request dropped unasked");
  AST_UIRQ_FALL: assert property (
    $fell(undervolt_irq) |-> $past(reg_wr)) else $error("undervolt request dropped unasked");
  AST_ABORT: assert property (
    rsvd_abort_en && reg_rd && reg_addr == `STM_OFF_RSVD |=> reg_abort)
    else $error("reserved access not aborted");
  AST_ABORT_CAUSE: assert property (
    reg_abort |-> $past(rsvd_abort_en && (reg_rd || reg_wr))) else $error("stray abort");
  cover property ($rose(temp_irq));
  cover property ($rose(undervolt_irq));
  cover property (reg_abort);
endmodule // stm_regs_sva
bind stm_regs stm_regs_sva chk_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_abort(reg_abort), .special_mode(special_mode), .rsvd_abort_en(rsvd_abort_en),
  .full_performance_mode(full_performance_mode), .temp_sense_enable(temp_sense_enable),
  .volt_access_enable(volt_access_enable), .volt_source_select(volt_source_select),
  .temp_test_bits(temp_test_bits), .temp_irq(temp_irq), .undervolt_irq(undervolt_irq));
`default_nettype wire

// [tb/test_supply_temp_monitor_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "stm_cfg.svh"
module test_supply_temp_monitor_regs;
  logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, special_mode = 0, rsvd_abort_en = 0;
  logic full_performance_mode = 0, reduced_power_mode = 0, over_temp_detector = 0;
  logic undervolt_detector = 0, reg_abort, temp_sense_enable, volt_access_enable;
  logic volt_source_select, temp_irq, undervolt_irq, irq;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0] reg_wdata = 8'h0, reg_rdata, d, w;
  logic [1:0] temp_test_bits;
  int n_fail = 0, comparisons = 0;
  always #4 mclk = ~mclk;
  stm_regs dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_abort(reg_abort),
    .special_mode(special_mode), .rsvd_abort_en(rsvd_abort_en),
    .full_performance_mode(full_performance_mode), .reduced_power_mode(reduced_power_mode),
    .over_temp_detector(over_temp_detector), .undervolt_detector(undervolt_detector),
    .temp_sense_enable(temp_sense_enable), .volt_access_enable(volt_access_enable),
    .volt_source_select(volt_source_select), .temp_test_bits(temp_test_bits),
    .temp_irq(temp_irq), .undervolt_irq(undervolt_irq), .irq(irq));
  function automatic logic [7:0] f_ctl(input logic [7:0] v);
    return {2'b00, v[5:3], 1'b0, v[1], 1'b0};
  endfunction
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
  initial begin
    void'($urandom(80));
    idle(16);
    rst_n <= 1'b1;
    rd(`STM_OFF_UV_CTRL);
    ck(d, 8'h00);
    repeat (6) begin
      w = 8'($urandom) & 8'h3e;
      wr(`STM_OFF_TEMP_CTRL, w);
      rd(`STM_OFF_TEMP_CTRL);
      ck(d & 8'h3f, f_ctl(w));
      ck({5'h0, volt_source_select, volt_access_enable, temp_sense_enable}, {5'h0, w[5:3]});
    end
    wr(`STM_OFF_TEMP_CTRL, 8'hc0);
    ck({6'h0, temp_test_bits}, 8'h00);
    special_mode <= 1'b1;
    wr(`STM_OFF_TEMP_CTRL, 8'hc0);
    ck({6'h0, temp_test_bits}, 8'h03);
    full_performance_mode <= 1'b1;
    wr(`STM_OFF_TEMP_CTRL, 8'h0a);
    special_mode <= 1'b0;
    idle(4);
    over_temp_detector <= 1'b1;
    idle(6);
    ck({7'h0, temp_irq}, 8'h01);
    rd(`STM_OFF_TEMP_CTRL);
    ck(d & 8'h3f, 8'h0f);
    wr(`STM_OFF_TEMP_CTRL, 8'h0a);
    ck({7'h0, temp_irq}, 8'h01);
    wr(`STM_OFF_TEMP_CTRL, 8'h0b);
    ck({7'h0, temp_irq}, 8'h00);
    over_temp_detector <= 1'b0;
    idle(6);
    ck({7'h0, temp_irq}, 8'h01);
    wr(`STM_OFF_TEMP_CTRL, 8'h08);
    ck({7'h0, temp_irq}, 8'h00);
    wr(`STM_OFF_UV_CTRL, 8'h02);
    undervolt_detector <= 1'b1;
    idle(6);
    ck({7'h0, undervolt_irq}, 8'h01);
    rd(`STM_OFF_UV_CTRL);
    ck(d, 8'h07);
    wr(`STM_OFF_UV_CTRL, 8'h03);
    ck({7'h0, undervolt_irq}, 8'h00);
    full_performance_mode <= 1'b0;
    reduced_power_mode <= 1'b1;
    idle(8);
    rd(`STM_OFF_UV_CTRL);
    ck(d, 8'h03);
    rd(`STM_OFF_TEMP_CTRL);
    ck(d & 8'h3f, 8'h09);
    ck({6'h0, undervolt_irq, irq}, 8'h03);
    wr(`STM_OFF_IRQ_MASK, 8'h00);
    ck({7'h0, irq}, 8'h00);
    wr(`STM_OFF_IRQ_STAT, 8'h02);
    ck({7'h0, undervolt_irq}, 8'h00);
    rsvd_abort_en <= 1'b1;
    rd(`STM_OFF_RSVD);
    ck({reg_abort, d[6:0]}, 8'h80);
    rd(16'h0300);
    ck({reg_abort, d[6:0]}, 8'h80);
    final_report();
  end
endmodule // test_supply_temp_monitor_regs
`default_nettype wire

// [verilog/stm_cfg.svh]
`ifndef STM_CFG_SVH
`define STM_CFG_SVH

// register offsets (byte addresses within the slice)
`define STM_ADDR_W 16
`define STM_OFF_TEMP_CTRL 16'h02f0
`define STM_OFF_UV_CTRL 16'h02f1
`define STM_OFF_WAKE_CTRL 16'h02f2
`define STM_OFF_WAKE_TRIM 16'h02f3
`define STM_OFF_RATE_HI 16'h02f4
`define STM_OFF_RATE_LO 16'h02f5
`define STM_OFF_RSVD 16'h02f6
`define STM_OFF_SENS_TRIM 16'h02f7
`define STM_OFF_IRQ_STAT 16'h02f8
`define STM_OFF_IRQ_MASK 16'h02f9

// field positions
`define STM_B_CHG_FLAG 0
`define STM_B_IRQ_EN 1
`define STM_B_STATUS 2
`define STM_B_SENSE_EN 3
`define STM_B_ACCESS_EN 4
`define STM_B_SRC_SEL 5
`define STM_B_TEST_LO 6
`define STM_B_TEST_HI 7
`define STM_B_TRIM_OVR 7

// field masks of storage registers
`define STM_WAKE_CTRL_MASK 8'h9e
`define STM_WAKE_TRIM_MASK 8'hfc
`define STM_SENS_TRIM_MASK 8'h8f

// reset values
`define STM_RST_BYTE 8'h00
`define STM_RST_MASK 2'h3

`endif

// [verilog/stm_pkg.sv]
package stm_pkg;
  typedef logic [7:0] stm_byte_t;
  typedef enum logic [1:0] {
    STM_MODE_FULL,
    STM_MODE_REDUCED,
    STM_MODE_SHUTDOWN
  } stm_mode_t;
endpackage

// [verilog/stm_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "stm_cfg.svh"

module stm_regs
  import stm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [`STM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_abort,
  // system level
  input wire logic special_mode,
  input wire logic rsvd_abort_en,
  input wire logic full_performance_mode,
  input wire logic reduced_power_mode,
  // analog detector outputs (asynchronous)
  input wire logic over_temp_detector,
  input wire logic undervolt_detector,
  // analog controls
  output logic temp_sense_enable,
  output logic volt_access_enable,
  output logic volt_source_select,
  output logic [1:0] temp_test_bits,
  // interrupt requests
  output logic temp_irq,
  output logic undervolt_irq,
  output logic irq
);

  // detector synchronisers
  logic ot_s1_q, ot_s2_q, uv_s1_q, uv_s2_q;
  logic full_s1_q, full_s2_q, red_s1_q, red_s2_q;
  logic over_temp_status_q, undervolt_status_q;
  logic temp_change_flag_q, undervolt_change_flag_q;
  logic temp_irq_enable_q, undervolt_irq_enable_q;
  logic [1:0] irq_mask_q;
  stm_mode_t mode_q;
  stm_byte_t wake_ctrl_q, wake_trim_q, rate_hi_q, rate_lo_q, sens_trim_q;

  logic hit_temp, hit_uv, hit_rsvd, hit_stat, hit_mask, mapped;
  logic over_temp_d, undervolt_d, temp_chg_set, uv_chg_set;
  logic temp_chg_clr, uv_chg_clr;
  logic temp_ie_d, uv_ie_d, temp_req_d, uv_req_d;
  logic [1:0] irq_mask_d;
  logic [7:0] rdata_d;

  assign hit_temp = (reg_addr == `STM_OFF_TEMP_CTRL);
  assign hit_uv = (reg_addr == `STM_OFF_UV_CTRL);
  assign hit_rsvd = (reg_addr == `STM_OFF_RSVD);
  assign hit_stat = (reg_addr == `STM_OFF_IRQ_STAT);
  assign hit_mask = (reg_addr == `STM_OFF_IRQ_MASK);
  assign mapped = (reg_addr >= `STM_OFF_TEMP_CTRL) && (reg_addr <= `STM_OFF_IRQ_MASK);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ot_s1_q <= 1'b0;
      ot_s2_q <= 1'b0;
      uv_s1_q <= 1'b0;
      uv_s2_q <= 1'b0;
      full_s1_q <= 1'b0;
      full_s2_q <= 1'b0;
      red_s1_q <= 1'b0;
      red_s2_q <= 1'b0;
    end else begin
      ot_s1_q <= over_temp_detector;
      ot_s2_q <= ot_s1_q;
      uv_s1_q <= undervolt_detector;
      uv_s2_q <= uv_s1_q;
      full_s1_q <= full_performance_mode;
      full_s2_q <= full_s1_q;
      red_s1_q <= reduced_power_mode;
      red_s2_q <= red_s1_q;
    end
  end

  // operating mode tracking
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= STM_MODE_SHUTDOWN;
    end else if (full_s2_q) begin
      mode_q <= STM_MODE_FULL;
    end else if (red_s2_q) begin
      mode_q <= STM_MODE_REDUCED;
    end else begin
      mode_q <= STM_MODE_SHUTDOWN;
    end
  end

  // detectors only count in full mode; sensor needs its enable
  always_comb begin
    case (mode_q)
      STM_MODE_FULL: begin
        over_temp_d = ot_s2_q & temp_sense_enable;
        undervolt_d = uv_s2_q;
      end
      STM_MODE_REDUCED, STM_MODE_SHUTDOWN: begin
        over_temp_d = 1'b0;
        undervolt_d = 1'b0;
      end
      default: begin
        over_temp_d = 1'b0;
        undervolt_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      over_temp_status_q <= 1'b0;
      undervolt_status_q <= 1'b0;
    end else begin
      over_temp_status_q <= over_temp_d;
      undervolt_status_q <= undervolt_d;
    end
  end

  assign temp_chg_set = over_temp_d != over_temp_status_q;
  assign uv_chg_set = undervolt_d != undervolt_status_q;
  assign temp_chg_clr = reg_wr && (hit_temp || hit_stat) && reg_wdata[`STM_B_CHG_FLAG];
  assign uv_chg_clr = reg_wr && ((hit_uv && reg_wdata[`STM_B_CHG_FLAG]) ||
                                 (hit_stat && reg_wdata[1]));

  // next enables and mask, so a request drops on the same edge that disables it
  assign temp_ie_d = (reg_wr && hit_temp) ? reg_wdata[`STM_B_IRQ_EN] : temp_irq_enable_q;
  assign uv_ie_d = (reg_wr && hit_uv) ? reg_wdata[`STM_B_IRQ_EN] : undervolt_irq_enable_q;
  assign irq_mask_d = (reg_wr && hit_mask) ? reg_wdata[1:0] : irq_mask_q;
  assign temp_req_d = temp_change_flag_q & ~temp_chg_clr & temp_ie_d;
  assign uv_req_d = undervolt_change_flag_q & ~uv_chg_clr & uv_ie_d;

  // change flags: set wins over clear; leaving full mode sets them when a status was high
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      temp_change_flag_q <= 1'b0;
      undervolt_change_flag_q <= 1'b0;
    end else begin
      if (temp_chg_set) begin
        temp_change_flag_q <= 1'b1;
      end else if (temp_chg_clr) begin
        temp_change_flag_q <= 1'b0;
      end
      if (uv_chg_set) begin
        undervolt_change_flag_q <= 1'b1;
      end else if (uv_chg_clr) begin
        undervolt_change_flag_q <= 1'b0;
      end
    end
  end

  // temperature control register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      temp_irq_enable_q <= 1'b0;
      temp_sense_enable <= 1'b0;
      volt_access_enable <= 1'b0;
      volt_source_select <= 1'b0;
      temp_test_bits <= 2'h0;
    end else if (reg_wr && hit_temp) begin
      temp_irq_enable_q <= reg_wdata[`STM_B_IRQ_EN];
      temp_sense_enable <= reg_wdata[`STM_B_SENSE_EN];
      volt_access_enable <= reg_wdata[`STM_B_ACCESS_EN];
      volt_source_select <= reg_wdata[`STM_B_SRC_SEL];
      if (special_mode) begin
        temp_test_bits <= reg_wdata[`STM_B_TEST_HI:`STM_B_TEST_LO];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      undervolt_irq_enable_q <= 1'b0;
    end else if (reg_wr && hit_uv) begin
      undervolt_irq_enable_q <= reg_wdata[`STM_B_IRQ_EN];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_mask_q <= `STM_RST_MASK;
    end else if (reg_wr && hit_mask) begin
      irq_mask_q <= reg_wdata[1:0];
    end
  end

  // periodic wakeup and trim storage; map only, no timer here
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wake_ctrl_q <= `STM_RST_BYTE;
      wake_trim_q <= `STM_RST_BYTE;
      rate_hi_q <= `STM_RST_BYTE;
      rate_lo_q <= `STM_RST_BYTE;
      sens_trim_q <= `STM_RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `STM_OFF_WAKE_CTRL) begin
        wake_ctrl_q <= reg_wdata & `STM_WAKE_CTRL_MASK;
      end
      if (reg_addr == `STM_OFF_WAKE_TRIM) begin
        wake_trim_q <= reg_wdata & `STM_WAKE_TRIM_MASK;
      end
      if (reg_addr == `STM_OFF_RATE_HI) begin
        rate_hi_q <= reg_wdata;
      end
      if (reg_addr == `STM_OFF_RATE_LO) begin
        rate_lo_q <= reg_wdata;
      end
      if (reg_addr == `STM_OFF_SENS_TRIM) begin
        sens_trim_q <= reg_wdata & `STM_SENS_TRIM_MASK;
      end
    end
  end

  // interrupt requests, registered levels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      temp_irq <= 1'b0;
      undervolt_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      temp_irq <= temp_req_d;
      undervolt_irq <= uv_req_d;
      irq <= (temp_req_d & irq_mask_d[0]) | (uv_req_d & irq_mask_d[1]);
    end
  end

  // read mux
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      `STM_OFF_TEMP_CTRL: begin
        rdata_d = {temp_test_bits, volt_source_select, volt_access_enable, temp_sense_enable,
                   over_temp_status_q, temp_irq_enable_q, temp_change_flag_q};
      end
      `STM_OFF_UV_CTRL: begin
        rdata_d = {5'h00, undervolt_status_q, undervolt_irq_enable_q, undervolt_change_flag_q};
      end
      `STM_OFF_WAKE_CTRL: rdata_d = wake_ctrl_q;
      `STM_OFF_WAKE_TRIM: rdata_d = wake_trim_q;
      `STM_OFF_RATE_HI: rdata_d = rate_hi_q;
      `STM_OFF_RATE_LO: rdata_d = rate_lo_q;
      `STM_OFF_SENS_TRIM: rdata_d = sens_trim_q;
      `STM_OFF_IRQ_STAT: rdata_d = {6'h00, undervolt_change_flag_q, temp_change_flag_q};
      `STM_OFF_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_abort <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
      reg_abort <= (reg_rd || reg_wr) && rsvd_abort_en && (hit_rsvd || !mapped);
    end
  end

endmodule // stm_regs
`default_nettype wire
